// ===== hdl/rx_frame_queue_readout.sv
`timescale 1ns/1ps
`default_nettype none
module rx_frame_queue_readout #(
	parameter int FIFO_DEPTH = 16
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic bus_16bit_i,
	input wire rx_queue_pkg::reg_req_s req_i,
	output logic [15:0] reg_rdata_o,
	input wire logic hdr_valid_i,
	input wire rx_queue_pkg::frame_header_s hdr_i,
	output logic hdr_ready_o,
	input wire logic [15:0] frame_data_i,
	output logic frame_data_pop_o,
	output logic frame_release_o,
	output logic irq_n_o
);
	import rx_queue_pkg::*;

	localparam int CW = $clog2(FIFO_DEPTH + 1);

	frame_header_s head;
	frame_header_s hdr_cur;
	logic head_valid;
	logic head_pop;
	logic [CW-1:0] fifo_count;
	logic [7:0] queued;
	logic [7:0] threshold;
	logic [7:0] count_snap;
	logic [6:0] ctrl;
	logic int_en;
	logic rx_int;
	logic thr_hit;
	logic status_seen;
	logic count_seen;
	logic rd_fcnt;
	logic rd_status;
	logic rd_count;
	logic rd_data;
	logic wr_int_clear;
	logic next_status_seen;
	logic next_count_seen;
	logic dma_on;
	logic dma_q;
	burst_state_e burst;
	logic [BYTE_COUNT_W-1:0] bytes_read;
	logic [BYTE_COUNT_W-1:0] next_bytes;
	logic frame_done;

	// Frame end padded up to the next double word
	function automatic logic [BYTE_COUNT_W-1:0] padded_len(input logic [BYTE_COUNT_W-1:0] n);
		padded_len = (n + DWORD_ROUND) & DWORD_MASK;
	endfunction

	// Headers of received frames wait here; back-pressure goes to the receiver
	header_fifo #(
		.WIDTH($bits(frame_header_s)),
		.DEPTH(FIFO_DEPTH),
		.CW(CW)
	) u_fifo (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.in_valid_i(hdr_valid_i),
		.in_ready_o(hdr_ready_o),
		.in_data_i(hdr_i),
		.out_valid_o(head_valid),
		.out_ready_i(head_pop),
		.out_data_o(head),
		.count_o(fifo_count)
	);

	// Access decode
	assign queued = 8'(fifo_count);
	assign rd_fcnt = req_i.rd && req_i.addr == FRAME_COUNT_OFS;
	assign rd_status = req_i.rd && req_i.addr == HDR_STATUS_OFS;
	assign rd_count = req_i.rd && req_i.addr == HDR_COUNT_OFS;
	assign rd_data = req_i.rd && req_i.addr == QUEUE_DATA_OFS;
	assign wr_int_clear = req_i.wr && req_i.addr == INT_STATUS_OFS && req_i.be[1]
		&& req_i.wdata[RX_INT_BIT];
	assign dma_on = ctrl[DMA_START_BIT - CTRL_LO_BIT];
	assign thr_hit = ctrl[FCNT_EN_BIT - CTRL_LO_BIT] && queued >= threshold; // RULE2

	// Both header halves must be read, or the frame count read, before the next header steps in
	assign next_status_seen = status_seen || rd_status;
	assign next_count_seen = count_seen || rd_count;
	assign head_pop = head_valid && (rd_fcnt || (next_status_seen && next_count_seen)); // RULE6 RULE7

	// Host-written control, threshold and enable
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			ctrl <= CTRL_RESET;
			threshold <= BYTE_ZERO;
			int_en <= 1'b0;
		end else if (req_i.wr) begin
			if (req_i.addr == QUEUE_CTRL_OFS && req_i.be[0]) begin
				ctrl[4:0] <= req_i.wdata[7:CTRL_LO_BIT];
			end
			if (req_i.addr == QUEUE_CTRL_OFS && req_i.be[1]) begin
				ctrl[6:5] <= req_i.wdata[CTRL_HI_BIT:8];
			end
			if (req_i.addr == FRAME_COUNT_OFS && req_i.be[0]) begin
				threshold <= req_i.wdata[7:0]; // RULE2
			end
			if (req_i.addr == INT_ENABLE_OFS && req_i.be[1]) begin
				int_en <= req_i.wdata[RX_INT_BIT];
			end
		end
	end

	// Sticky receive interrupt; a new hit in the clearing cycle keeps it set
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			rx_int <= 1'b0;
		end else if (thr_hit) begin
			rx_int <= 1'b1; // RULE2
		end else if (wr_int_clear) begin
			rx_int <= 1'b0; // RULE12
		end
	end

	// Count snapshot taken as the interrupt rises and again when it is cleared
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			count_snap <= BYTE_ZERO;
		end else if ((thr_hit && !rx_int) || wr_int_clear) begin
			count_snap <= queued; // RULE1 RULE5
		end
	end

	// Header registers and the read-both tracking
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			hdr_cur <= '0;
			status_seen <= 1'b0;
			count_seen <= 1'b0;
		end else if (rd_fcnt || (next_status_seen && next_count_seen)) begin
			hdr_cur <= head_valid ? head : '0; // RULE6 RULE7
			status_seen <= 1'b0;
			count_seen <= 1'b0;
		end else begin
			status_seen <= next_status_seen;
			count_seen <= next_count_seen;
		end
	end

	// Burst progress: arm on the rising start bit, dummy unit first
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			dma_q <= 1'b0;
			burst <= BURST_IDLE;
		end else begin
			dma_q <= dma_on;
			unique case (burst)
				BURST_IDLE: begin
					if (dma_on && !dma_q) begin
						burst <= BURST_DUMMY; // RULE9
					end
				end
				BURST_DUMMY: begin
					if (!dma_on) begin
						burst <= BURST_IDLE;
					end else if (rd_data) begin
						burst <= BURST_DATA; // RULE3
					end
				end
				BURST_DATA: begin
					if (!dma_on) begin
						burst <= BURST_IDLE;
					end
				end
				default: begin
					burst <= BURST_IDLE;
				end
			endcase
		end
	end

	// Byte tracking; the host reads through padding, so pops run to the double word
	assign next_bytes = bytes_read + (bus_16bit_i ? UNIT_WORD : UNIT_BYTE);
	assign frame_data_pop_o = burst == BURST_DATA && rd_data; // RULE3
	assign frame_done = frame_data_pop_o && next_bytes >= padded_len(hdr_cur.byte_count); // RULE4

	always_ff @(posedge ref_clk_i) begin
		if (rst_i || burst != BURST_DATA) begin
			bytes_read <= '0;
		end else if (frame_done) begin
			bytes_read <= '0;
		end else if (frame_data_pop_o) begin
			bytes_read <= next_bytes;
		end
	end

	// Release pulse only in auto dequeue mode; otherwise software frees frames
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			frame_release_o <= 1'b0;
		end else begin
			frame_release_o <= frame_done && ctrl[AUTO_DEQ_BIT - CTRL_LO_BIT]; // RULE10
		end
	end

	// Interrupt pin is active low and gated by its enable
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			irq_n_o <= 1'b1;
		end else begin
			irq_n_o <= !(rx_int && int_en); // RULE11
		end
	end

	// Read data is registered; the dummy unit and unmapped offsets read zero
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			reg_rdata_o <= WORD_ZERO;
		end else if (req_i.rd) begin
			reg_rdata_o <= WORD_ZERO;
			unique case (req_i.addr)
				FRAME_COUNT_OFS: reg_rdata_o <= {count_snap, threshold}; // RULE1
				HDR_STATUS_OFS: reg_rdata_o <= hdr_cur.status;
				HDR_COUNT_OFS: reg_rdata_o <= 16'(hdr_cur.byte_count);
				QUEUE_CTRL_OFS: reg_rdata_o <= 16'({thr_hit, ctrl, 3'b000}); // RULE2
				INT_ENABLE_OFS: reg_rdata_o[RX_INT_BIT] <= int_en;
				INT_STATUS_OFS: reg_rdata_o[RX_INT_BIT] <= rx_int;
				QUEUE_DATA_OFS: begin
					if (burst == BURST_DATA) begin
						reg_rdata_o <= bus_16bit_i ? frame_data_i : {BYTE_ZERO, frame_data_i[7:0]};
					end
				end
				default: reg_rdata_o <= WORD_ZERO;
			endcase
		end
	end

	// Checks
	threshold_sets_int_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE2
		thr_hit |=> rx_int) else $error("threshold hit did not raise interrupt");
	int_gating_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE11
		$past(rx_int) && !$past(int_en) |-> irq_n_o) else $error("irq seen while disabled");
	int_reaches_pin_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE11
		rx_int && int_en |=> !irq_n_o) else $error("enabled interrupt missing on pin");
	clear_refresh_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE5
		wr_int_clear |=> count_snap == $past(queued)) else $error("count not refreshed on clear");
	clear_drops_int_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE12
		wr_int_clear && !thr_hit |=> !rx_int) else $error("write one did not clear");
	count_readback_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE1
		rd_fcnt |=> reg_rdata_o[15:8] == $past(count_snap)) else $error("bad frame count byte");
	header_load_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE6
		rd_fcnt && head_valid |=> hdr_cur == $past(head)) else $error("header not loaded");
	header_step_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE7
		rd_count && status_seen && !rd_fcnt && head_valid
		|=> hdr_cur == $past(head)) else $error("header did not step");
	dummy_first_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE3
		burst == BURST_DUMMY && rd_data |-> !frame_data_pop_o ##1 reg_rdata_o == WORD_ZERO)
		else $error("dummy unit not returned");
	release_mode_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE10
		frame_release_o |-> $past(ctrl[AUTO_DEQ_BIT - CTRL_LO_BIT])) else $error("release off");

	frame_released_c: cover property (@(posedge ref_clk_i) disable iff (rst_i) frame_release_o);
	int_cycle_c: cover property (@(posedge ref_clk_i) disable iff (rst_i)
		rx_int ##[1:50] wr_int_clear);
	dummy_then_data_c: cover property (@(posedge ref_clk_i) disable iff (rst_i)
		burst == BURST_DUMMY && rd_data ##[1:20] frame_data_pop_o);
	fifo_full_c: cover property (@(posedge ref_clk_i) disable iff (rst_i) !hdr_ready_o);
endmodule
`default_nettype wire

// ===== hdl/rx_queue_pkg.sv
// Summary of operation
// RULE1: The upper byte of the frame count register is read-only and shows the queued frame count captured when the receive interrupt was raised.
// RULE2: The lower byte of the frame count register is a threshold; when queued frames reach it with queue control bit 5 set, interrupt status bit 13 and queue control bit 10 are set.
// RULE3: The first unit of every queue read burst is dummy data (a byte in 8-bit mode, a word in 16-bit mode) that the host discards.
// RULE4: The host keeps reading each frame until its end is aligned to a double word, reading padding past the byte count.
// RULE5: Writing one to the receive interrupt status bit refreshes the frame count register for this interrupt.
// RULE6: Reading the frame count register loads the header status and byte count registers for the first queued frame.
// RULE7: Once both header registers have been read, both are loaded with the header of the next queued frame.
// RULE8: The host may poll or use the interrupt, and follows the same clear, count and header read sequence either way.
// RULE9: Setting queue control bit 3 starts a host access burst to the queue.
// RULE10: With queue control bit 4 set, frames are dequeued from the receive buffer automatically.
// RULE11: The receive interrupt reaches the host only while interrupt enable bit 13 is set.
// RULE12: Each interrupt status bit clears when one is written to it; writing all ones clears all; here the receive bit stays set while the threshold is met.
package rx_queue_pkg;

	// Register byte offsets
	localparam logic [7:0] HDR_STATUS_OFS = 8'h7C;
	localparam logic [7:0] HDR_COUNT_OFS = 8'h7E;
	localparam logic [7:0] QUEUE_DATA_OFS = 8'h80;
	localparam logic [7:0] QUEUE_CTRL_OFS = 8'h82;
	localparam logic [7:0] INT_ENABLE_OFS = 8'h90;
	localparam logic [7:0] INT_STATUS_OFS = 8'h92;
	localparam logic [7:0] FRAME_COUNT_OFS = 8'h9C;

	// Field positions
	localparam int DMA_START_BIT = 3;
	localparam int AUTO_DEQ_BIT = 4;
	localparam int FCNT_EN_BIT = 5;
	localparam int FCNT_STAT_BIT = 10;
	localparam int RX_INT_BIT = 13;
	localparam int CTRL_LO_BIT = 3;
	localparam int CTRL_HI_BIT = 9;

	// Reset values and widths
	localparam logic [15:0] WORD_ZERO = 16'h0000;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [6:0] CTRL_RESET = 7'h00;
	localparam int BYTE_COUNT_W = 12;
	localparam logic [BYTE_COUNT_W-1:0] DWORD_MASK = 12'hFFC;
	localparam logic [BYTE_COUNT_W-1:0] DWORD_ROUND = 12'h003;
	localparam logic [BYTE_COUNT_W-1:0] UNIT_BYTE = 12'h001;
	localparam logic [BYTE_COUNT_W-1:0] UNIT_WORD = 12'h002;

	// Header of one received frame
	typedef struct packed {
		logic [15:0] status;
		logic [BYTE_COUNT_W-1:0] byte_count;
	} frame_header_s;

	// Register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [1:0] be;
		logic [15:0] wdata;
	} reg_req_s;

	// Queue read burst progress
	typedef enum logic [1:0] {
		BURST_IDLE = 2'b00,
		BURST_DUMMY = 2'b01,
		BURST_DATA = 2'b10
	} burst_state_e;

endpackage

// ===== hdl/header_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module header_fifo #(
	parameter int WIDTH = 28,
	parameter int DEPTH = 16,
	parameter int CW = $clog2(DEPTH + 1)
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o,
	output logic [CW-1:0] count_o
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic push;
	logic pop;

	// Full and empty come straight from the occupancy count
	assign in_ready_o = count_o != CW'(DEPTH);
	assign out_valid_o = count_o != '0;
	assign out_data_o = mem[rd_ptr];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	// Storage, no reset needed on the array
	always_ff @(posedge ref_clk_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	// Pointers wrap explicitly so DEPTH need not be a power of two
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count_o <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			count_o <= count_o + CW'(push) - CW'(pop);
		end
	end
endmodule
`default_nettype wire

// ===== verification/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic ref_clk_i,
	input wire logic [15:0] rdata_i,
	output var rx_queue_pkg::reg_req_s req_o
);
	import rx_queue_pkg::*;

	// Bus idle from time zero
	initial begin
		req_o = '0;
	end

	// One strobe cycle, then idle for a cycle, so two strobes never merge
	// The host only collects frames through this access, polled or not
	task automatic access(input logic [7:0] a, input logic w, input logic [1:0] be,
		input logic [15:0] wd, output logic [15:0] rd_data);
		@(posedge ref_clk_i);
		req_o <= '{addr: a, wr: w, rd: !w, be: be, wdata: wd};
		@(posedge ref_clk_i);
		req_o <= '0;
		#1 rd_data = rdata_i;
	endtask

	// Whole frame read: dummy unit first, then data up to the double-word pad
	task automatic read_frame(input int units, output logic [15:0] d[$]);
		logic [15:0] v;
		d = {};
		access(QUEUE_DATA_OFS, 1'b0, 2'b11, 16'h0000, v);
		d.push_back(v);
		for (int i = 0; i < units; i++) begin
			access(QUEUE_DATA_OFS, 1'b0, 2'b11, 16'h0000, v);
			d.push_back(v);
		end
	endtask
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import rx_queue_pkg::*;

	logic ref_clk_i, rst_i, bus_16bit_i, hdr_valid_i;
	logic frame_data_pop_o, frame_release_o, irq_n_o, hdr_ready_o;
	frame_header_s hdr_i;
	reg_req_s req_i;
	logic [15:0] reg_rdata_o, frame_data_i, idx, d;
	int err_count, n_checks, rel_cnt;
	logic [15:0] q[$];

	rx_frame_queue_readout #(.FIFO_DEPTH(16)) i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
		.bus_16bit_i(bus_16bit_i), .req_i(req_i), .reg_rdata_o(reg_rdata_o),
		.hdr_valid_i(hdr_valid_i), .hdr_i(hdr_i), .hdr_ready_o(hdr_ready_o),
		.frame_data_i(frame_data_i), .frame_data_pop_o(frame_data_pop_o),
		.frame_release_o(frame_release_o), .irq_n_o(irq_n_o));
	host_model u_host (.ref_clk_i(ref_clk_i), .rdata_i(reg_rdata_o), .req_o(req_i));

	// Clock, 100 ns period
	initial begin
		ref_clk_i = 1'b0;
		forever #50 ref_clk_i = ~ref_clk_i;
	end

	// Frame store: each word is distinct, so a skipped pop shows as a wrong value
	assign frame_data_i = 16'hA000 + idx;
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			idx <= 16'h0000;
			rel_cnt <= 0;
		end else begin
			if (frame_data_pop_o) idx <= idx + 16'h0001;
			if (frame_release_o) rel_cnt <= rel_cnt + 1;
		end
	end

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic rd(input logic [7:0] a, output logic [15:0] v);
		u_host.access(a, 1'b0, 2'b11, 16'h0000, v);
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] v, input logic [1:0] be);
		u_host.access(a, 1'b1, be, v, d);
	endtask

	// Offer n headers back to back, valid held high throughout
	task automatic push(input int n, input logic [15:0] st, input logic [11:0] bc);
		for (int i = 0; i < n; i++) begin
			@(posedge ref_clk_i);
			hdr_valid_i <= 1'b1;
			hdr_i <= '{status: st + 16'(i), byte_count: bc + 12'(2 * i)};
		end
		@(posedge ref_clk_i);
		hdr_valid_i <= 1'b0;
	endtask

	task automatic t_reset;
		rd(FRAME_COUNT_OFS, d);
		check("frame count", d, 16'h0000);
		rd(QUEUE_CTRL_OFS, d);
		check("queue ctrl", d, 16'h0000);
		rd(8'hAA, d);
		check("unmapped", d, 16'h0000);
		check("irq idle", {15'h0000, irq_n_o}, 16'h0001);
	endtask

	task automatic t_thresh;
		wr(FRAME_COUNT_OFS, 16'hFF02, 2'b11);
		wr(QUEUE_CTRL_OFS, 16'h0030, 2'b11);
		push(2, 16'h8001, 12'h003);
		rd(QUEUE_CTRL_OFS, d);
		check("ctrl hit", d, 16'h0430);
		rd(INT_STATUS_OFS, d);
		check("int status", d, 16'h2000);
		check("irq masked", {15'h0000, irq_n_o}, 16'h0001);
		wr(INT_ENABLE_OFS, 16'h2000, 2'b11);
		rd(INT_STATUS_OFS, d);
		check("irq on", {15'h0000, irq_n_o}, 16'h0000);
		push(1, 16'h8003, 12'h007);
		wr(FRAME_COUNT_OFS, 16'h0004, 2'b01);
		wr(INT_STATUS_OFS, 16'hFFFF, 2'b11);
		rd(FRAME_COUNT_OFS, d);
		check("count snap", d, 16'h0304);
		wr(INT_STATUS_OFS, 16'hFFFF, 2'b11);
		rd(INT_STATUS_OFS, d);
		check("status clr", d, 16'h0000);
		check("irq off", {15'h0000, irq_n_o}, 16'h0001);
	endtask

	task automatic t_burst(input logic [15:0] first, input int units, input logic [15:0] mask);
		wr(QUEUE_CTRL_OFS, 16'h0030, 2'b11);
		wr(QUEUE_CTRL_OFS, 16'h0038, 2'b11);
		u_host.read_frame(units, q);
		check("dummy", q[0], 16'h0000);
		for (int i = 1; i <= units; i++) begin
			check("data", q[i] & mask, (first + 16'(i - 1)) & mask);
		end
		@(posedge ref_clk_i);
		#1 check("pops", frame_data_i, first + 16'(units));
	endtask

	initial begin
		err_count = 0;
		n_checks = 0;
		rst_i = 1'b1;
		bus_16bit_i = 1'b1;
		hdr_valid_i = 1'b0;
		hdr_i = '0;
		repeat (20) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_thresh();
		rd(HDR_STATUS_OFS, d);
		check("hdr status", d, 16'h8001);
		t_burst(16'hA000, 2, 16'hFFFF);
		check("release", 16'(rel_cnt), 16'h0001);
		rd(HDR_COUNT_OFS, d);
		check("hdr count", d, 16'h0003);
		rd(HDR_STATUS_OFS, d);
		check("next status", d, 16'h8002);
		@(posedge ref_clk_i);
		bus_16bit_i <= 1'b0;
		t_burst(16'hA002, 8, 16'h00FF);
		check("release 2", 16'(rel_cnt), 16'h0002);
		push(16, 16'h9000, 12'h010);
		#1 check("fifo full", {15'h0000, hdr_ready_o}, 16'h0000);
		summarize();
	end

	// Watchdog well beyond the hundred or so cycles the tests need
	initial begin
		#500000;
		err_count++;
		summarize();
	end

	task automatic summarize;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
endmodule
`default_nettype wire
